// [bcdr_defines.svh]
// Purpose: Subaddresses, field positions and reset values of the
//          burst receiver's control registers.
// Assumes: Included by its bare name.
// Notes: Field ranges are usable directly as part-selects.
`ifndef BCDR_DEFINES_SVH
`define BCDR_DEFINES_SVH

// Register subaddresses
`define BCDR_SUB_LOCKSET 3'h0
`define BCDR_SUB_ACQ 3'h1
`define BCDR_SUB_FMT 3'h2
`define BCDR_SUB_PATH 3'h3
`define BCDR_SUB_STATUS 3'h4

// Reset values
`define BCDR_LOCKSET_RST 8'h00
`define BCDR_ACQ_RST 8'h00
`define BCDR_FMT_RST 8'h00
`define BCDR_PATH_RST 8'h00

// reference_lock_setup fields
`define BCDR_LS_EN 0
`define BCDR_LS_RATIO 5:2
`define BCDR_LS_RANGE 7:6
`define BCDR_RATIO_MAX 4'h8

// acquisition_control fields
`define BCDR_ACQ_GO 5

// output_format_control fields
`define BCDR_FMT_REV 5
`define BCDR_FMT_DDR 4
`define BCDR_FMT_PHASE 3:2

// output_path_control fields
`define BCDR_PATH_SERIAL 7
`define BCDR_PATH_DAT_OFF 6
`define BCDR_PATH_CLK_OFF 5
`define BCDR_PATH_SER_FULL 0

// Status fields
`define BCDR_ST_OVF 0
`define BCDR_ST_SERIAL 1

// Clock edge placement in half-UI slots
`define BCDR_RISE_PAR 4'h4
`define BCDR_RISE_SER 4'h1
`define BCDR_OFS_BASE 4'h0
`define BCDR_OFS_P2UI 4'h4
`define BCDR_OFS_P05UI 4'h1
`define BCDR_OFS_M15UI 4'hd
`define BCDR_MASK_PAR 4'h7
`define BCDR_MASK_DDR 4'hf
`define BCDR_MASK_SER 4'h3
`define BCDR_MASK_SERF 4'h1

`endif

// [bcdr_pkg.sv]
// Purpose: Types shared by the burst receiver output logic.
// Assumes: Nothing.
// Notes: Word layout is also the buffer's data layout.
package bcdr_pkg;

  // One buffered output word
  typedef struct packed {
    logic serial;
    logic [3:0] nib;
  } bcdr_word_s;

  // Output format active for one 8-UI frame
  typedef struct packed {
    logic serial;
    logic rev;
    logic ddr;
    logic ser_full;
    logic [1:0] phase;
    logic clk_off;
    logic dat_off;
  } bcdr_cfg_s;

endpackage

// [bcdr_mem.sv]
// Purpose: Small dual-port store with registered read data.
// Assumes: Read and write on the same clock.
// Notes: Write-first, so a same-cycle write is seen on read.
`timescale 1ns/1ps
module bcdr_mem #(
  parameter int W = 5,
  parameter int D = 16,
  parameter int AW = $clog2(D)
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata_q
);

  logic [W-1:0] mem_q [D];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (we)
      mem_q[waddr] <= wdata;
  end

  // Read with write bypass avoids a stale head word
  always_ff @(posedge clk)
  begin
    rdata_q <= (we && waddr == raddr) ? wdata : mem_q[raddr];
  end

endmodule // bcdr_mem

// [bcdr_fifo.sv]
// Purpose: Show-ahead FIFO between deserializer and output stage.
// Assumes: Synchronous reset, single clock.
// Notes: Ready and valid are flops, so both ends see clean levels.
`timescale 1ns/1ps
module bcdr_fifo #(
  parameter int W = 5,
  parameter int D = 16,
  parameter int AW = $clog2(D)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready_q,
  input wire logic [W-1:0] in_data,
  output logic out_valid_q,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] rd_ptr_d;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  // Handshakes and next pointers
  assign push = in_valid && in_ready_q;
  assign pop = out_ready && out_valid_q;
  assign rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
  assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);

  // Pointers, fill level and flags
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready_q <= 1'b0;
      out_valid_q <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      in_ready_q <= count_d < (AW+1)'(D);
      out_valid_q <= count_d != '0;
    end
  end

  bcdr_mem #(.W(W), .D(D)) u_mem (
    .clk(clk),
    .we(push),
    .waddr(wr_ptr_q),
    .wdata(in_data),
    .raddr(rd_ptr_d),
    .rdata_q(out_data)
  );

endmodule // bcdr_fifo

// [bcdr_top.sv]
// Purpose: Reference-ratio setup and output formatting of a burst
//          clock and data recovery receiver.
// Assumes: One rx_bit per clk while rx_valid; clk is the bit clock.
// Notes: Output clock is given as two half-UI slots per cycle.
`timescale 1ns/1ps
`include "bcdr_defines.svh"
module bcdr_top
  import bcdr_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rx_bit,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_ack_q,
  output logic ref_lock_en_q,
  output logic [1:0] ref_range_q,
  output logic [3:0] ref_div_q,
  output logic [8:0] lock_multiple_q,
  output logic acq_start_q,
  output logic [3:0] par_lanes_q,
  output logic data_oe_q,
  output logic [1:0] rclk_out_q,
  output logic rclk_oe_q
);

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Lane order reversal
  function automatic logic [3:0] bit_rev(input logic [3:0] v);
    bit_rev = {v[0], v[1], v[2], v[3]};
  endfunction

  // Clock level in one half-UI slot
  function automatic logic clk_lvl(input logic [3:0] slot,
                                   input logic [3:0] rise,
                                   input logic [3:0] pmask);
    logic [3:0] d;
    d = (slot - rise) & pmask;
    clk_lvl = d <= (pmask >> 1);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] lockset_q;
  logic [7:0] acq_q;
  logic [7:0] fmt_q;
  logic [7:0] path_q;
  logic ovf_q;
  logic sub_ok;
  logic wr_lockset;
  logic wr_acq;
  logic wr_fmt;
  logic wr_path;
  logic wr_status;
  bcdr_cfg_s cfg_q;
  bcdr_cfg_s cfg_d;

  // Subaddress decode; others get no acknowledge
  assign sub_ok = reg_addr <= `BCDR_SUB_STATUS;
  assign wr_lockset = reg_wr_en && reg_addr == `BCDR_SUB_LOCKSET;
  assign wr_acq = reg_wr_en && reg_addr == `BCDR_SUB_ACQ;
  assign wr_fmt = reg_wr_en && reg_addr == `BCDR_SUB_FMT;
  assign wr_path = reg_wr_en && reg_addr == `BCDR_SUB_PATH;
  assign wr_status = reg_wr_en && reg_addr == `BCDR_SUB_STATUS;

  // Control register writes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lockset_q <= `BCDR_LOCKSET_RST;
      acq_q <= `BCDR_ACQ_RST;
      fmt_q <= `BCDR_FMT_RST;
      path_q <= `BCDR_PATH_RST;
    end
    else
    begin
      if (wr_lockset)
        lockset_q <= reg_wdata;
      if (wr_acq)
        acq_q <= reg_wdata;
      if (wr_fmt)
        fmt_q <= reg_wdata;
      if (wr_path)
        path_q <= reg_wdata;
    end
  end

  // Read data and acknowledge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata_q <= 8'h00;
      reg_ack_q <= 1'b0;
    end
    else
    begin
      reg_ack_q <= (reg_wr_en || reg_rd_en) && sub_ok;
      if (reg_rd_en)
      begin
        unique case (reg_addr)
          `BCDR_SUB_LOCKSET: reg_rdata_q <= lockset_q;
          `BCDR_SUB_ACQ: reg_rdata_q <= acq_q;
          `BCDR_SUB_FMT: reg_rdata_q <= fmt_q;
          `BCDR_SUB_PATH: reg_rdata_q <= path_q;
          `BCDR_SUB_STATUS: reg_rdata_q <= {6'h00, cfg_q.serial, ovf_q};
          default: reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frequency loop setup

  // Exponents to loop controls; codes above 8 clamp to 256
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ref_lock_en_q <= 1'b0;
      ref_range_q <= 2'h0;
      ref_div_q <= 4'h1;
      lock_multiple_q <= 9'h001;
    end
    else
    begin
      ref_lock_en_q <= lockset_q[`BCDR_LS_EN];
      ref_range_q <= lockset_q[`BCDR_LS_RANGE];
      ref_div_q <= 4'h1 << lockset_q[`BCDR_LS_RANGE];
      if (lockset_q[`BCDR_LS_RATIO] > `BCDR_RATIO_MAX)
        lock_multiple_q <= 9'h100;
      else
        lock_multiple_q <= 9'h001 << lockset_q[`BCDR_LS_RATIO];
    end
  end

  // Rising write of acquisition bit starts acquisition
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acq_start_q <= 1'b0;
    else
      acq_start_q <= wr_acq && reg_wdata[`BCDR_ACQ_GO] && !acq_q[`BCDR_ACQ_GO];
  end

  ////////////////////////////////////////////////////////////////////
  // Deserializer

  logic [1:0] des_cnt_q;
  logic [2:0] des_sh_q;
  logic in_serial_q;
  logic in_serial;
  logic push_valid;
  logic fifo_in_ready;
  bcdr_word_s push_word;

  // Path switch taken only between nibbles
  assign in_serial = des_cnt_q == 2'h0 ? path_q[`BCDR_PATH_SERIAL] : in_serial_q;
  assign push_valid = rx_valid && (in_serial || des_cnt_q == 2'h3);
  assign push_word.serial = in_serial;
  assign push_word.nib = in_serial ? {3'h0, rx_bit} : {des_sh_q, rx_bit};
  assign rx_ready = fifo_in_ready;

  // Bit gathering, earliest bit ends in bit 3
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      des_cnt_q <= 2'h0;
      des_sh_q <= 3'h0;
      in_serial_q <= 1'b0;
    end
    else if (rx_valid)
    begin
      in_serial_q <= in_serial;
      des_cnt_q <= in_serial ? 2'h0 : des_cnt_q + 2'h1;
      des_sh_q <= {des_sh_q[1:0], rx_bit};
    end
  end

  // A lost word stays flagged until software clears it; set wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ovf_q <= 1'b0;
    else if (push_valid && !fifo_in_ready)
      ovf_q <= 1'b1;
    else if (wr_status && reg_wdata[`BCDR_ST_OVF])
      ovf_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Buffer

  logic head_valid;
  logic take;
  bcdr_word_s head;

  bcdr_fifo #(.W($bits(bcdr_word_s)), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_ready_q(fifo_in_ready),
    .in_data(push_word),
    .out_valid_q(head_valid),
    .out_ready(take),
    .out_data(head)
  );

  ////////////////////////////////////////////////////////////////////
  // Output stage

  logic [2:0] ui_q;
  logic [2:0] ui_d;
  logic [3:0] rise;
  logic [3:0] pmask;
  logic [3:0] ofs;

  // Live register view of the format
  assign cfg_d.serial = path_q[`BCDR_PATH_SERIAL];
  assign cfg_d.rev = fmt_q[`BCDR_FMT_REV];
  assign cfg_d.ddr = fmt_q[`BCDR_FMT_DDR];
  assign cfg_d.ser_full = path_q[`BCDR_PATH_SER_FULL];
  assign cfg_d.phase = fmt_q[`BCDR_FMT_PHASE];
  assign cfg_d.clk_off = path_q[`BCDR_PATH_CLK_OFF];
  assign cfg_d.dat_off = path_q[`BCDR_PATH_DAT_OFF];
  assign ui_d = ui_q + 3'h1;

  // UI position within the 8-UI frame; format latched at its end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ui_q <= 3'h0;
      cfg_q <= '0;
    end
    else
    begin
      ui_q <= ui_d;
      if (ui_q == 3'h7)
        cfg_q <= cfg_d;
    end
  end

  // Draining stalls while data buffers are off, so the FIFO backs up
  assign take = head_valid && !cfg_q.dat_off && (cfg_q.serial || ui_q[1:0] == 2'h3);

  // Lane driving
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      par_lanes_q <= 4'h0;
      data_oe_q <= 1'b0;
    end
    else
    begin
      data_oe_q <= !cfg_q.dat_off;
      if (cfg_q.dat_off)
        par_lanes_q <= 4'h0;
      else if (take && head.serial)
        par_lanes_q <= head.nib;
      else if (take)
        par_lanes_q <= cfg_q.rev ? bit_rev(head.nib) : head.nib;
    end
  end

  // Phase code to slot offset; 00 is the centred edge
  always_comb
  begin
    unique case (cfg_q.phase)
      2'h0: ofs = `BCDR_OFS_BASE;
      2'h1: ofs = `BCDR_OFS_P2UI;
      2'h2: ofs = `BCDR_OFS_P05UI;
      2'h3: ofs = `BCDR_OFS_M15UI;
    endcase
  end

  // Clock period and edge placement per mode
  always_comb
  begin
    if (cfg_q.serial)
    begin
      rise = `BCDR_RISE_SER;
      pmask = cfg_q.ser_full ? `BCDR_MASK_SERF : `BCDR_MASK_SER;
    end
    else
    begin
      rise = `BCDR_RISE_PAR + ofs;
      pmask = cfg_q.ddr ? `BCDR_MASK_DDR : `BCDR_MASK_PAR;
    end
  end

  // Two half-UI clock slots, aligned with the registered lanes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rclk_out_q <= 2'h0;
      rclk_oe_q <= 1'b0;
    end
    else
    begin
      rclk_oe_q <= !cfg_q.clk_off;
      if (cfg_q.clk_off)
        rclk_out_q <= 2'h0;
      else
        rclk_out_q <= {clk_lvl({ui_d, 1'b1}, rise, pmask),
                       clk_lvl({ui_d, 1'b0}, rise, pmask)};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] cfg_age_q;

  // Cycles since the active format last changed
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cfg_age_q <= 4'h0;
    else if (ui_q == 3'h7 && cfg_d != cfg_q)
      cfg_age_q <= 4'h0;
    else if (cfg_age_q != 4'hf)
      cfg_age_q <= cfg_age_q + 4'h1;
  end

  chk_acq_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_acq && reg_wdata[5] && !acq_q[5]) |=> acq_start_q ##1 !acq_start_q)
    else $error("acquisition start pulse wrong");

  chk_ref_div: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> ref_div_q == (4'h1 << $past(lockset_q[7:6])) &&
      ref_range_q == $past(lockset_q[7:6]))
    else $error("reference divider does not follow range");

  chk_ratio_mult: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(lockset_q[5:2]) <= 4'h8 && !$past(sys_rst)) |->
      lock_multiple_q == (9'h001 << $past(lockset_q[5:2])))
    else $error("lock multiple does not follow ratio");

  chk_cfg_boundary: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(cfg_q) |-> ui_q == 3'h0)
    else $error("format changed inside a frame");

  chk_lane_order: assert property (@(posedge clk) disable iff (sys_rst)
    (take && !head.serial && !cfg_q.dat_off) |=>
      par_lanes_q == ($past(cfg_q.rev) ? bit_rev($past(head.nib)) : $past(head.nib)))
    else $error("nibble lane order wrong");

  chk_serial_lane: assert property (@(posedge clk) disable iff (sys_rst)
    (take && head.serial && !cfg_q.dat_off) |=>
      par_lanes_q == {3'h0, $past(head.nib[0])})
    else $error("serial data not on lane 0 only");

  chk_par_full: assert property (@(posedge clk) disable iff (sys_rst)
    (!cfg_q.serial && !cfg_q.ddr && !cfg_q.clk_off && cfg_age_q > 4'h3) |->
      rclk_out_q == ~$past(rclk_out_q, 2))
    else $error("parallel clock not full rate");

  chk_par_ddr: assert property (@(posedge clk) disable iff (sys_rst)
    (!cfg_q.serial && cfg_q.ddr && !cfg_q.clk_off && cfg_age_q > 4'h5) |->
      rclk_out_q == ~$past(rclk_out_q, 4))
    else $error("parallel clock not divided by two");

  chk_ser_half: assert property (@(posedge clk) disable iff (sys_rst)
    (cfg_q.serial && !cfg_q.ser_full && !cfg_q.clk_off && cfg_age_q > 4'h2) |->
      rclk_out_q == ~$past(rclk_out_q))
    else $error("serial clock not half rate");

  chk_ser_full: assert property (@(posedge clk) disable iff (sys_rst)
    (cfg_q.serial && cfg_q.ser_full && !cfg_q.clk_off && cfg_age_q > 4'h1) |->
      rclk_out_q == 2'h2)
    else $error("serial clock not full rate");

  chk_phase_step: assert property (@(posedge clk) disable iff (sys_rst)
    (!cfg_q.serial && !cfg_q.ddr && !cfg_q.clk_off && cfg_age_q > 4'h1 &&
     ui_q[1:0] == 2'h2) |->
      rclk_out_q == (cfg_q.phase == 2'h0 ? 2'h3 : cfg_q.phase == 2'h1 ? 2'h0 :
                     cfg_q.phase == 2'h2 ? 2'h2 : 2'h1))
    else $error("clock phase offset wrong");

  chk_clk_off: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_q.clk_off |=> rclk_out_q == 2'h0 && !rclk_oe_q)
    else $error("clock buffers not disabled");

  chk_dat_off: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_q.dat_off |=> par_lanes_q == 4'h0 && !data_oe_q)
    else $error("data buffers not disabled");

endmodule // bcdr_top

// [bcdr_sink.sv]
// Purpose: Capturing logic model that sits on the formatted output lanes.
// Assumes: Lanes and clock halves are sampled once per bit clock.
// Notes: Rise position is counted in half-UI slots from the last lane change.
`timescale 1ns/1ps
module bcdr_sink (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] lanes,
  input wire logic [1:0] rclk,
  output logic [15:0] rise_cnt_q,
  output logic [7:0] last_pos_q,
  output logic [3:0] cap_q
);
  logic [3:0] prev_lanes_q;
  logic prev_half_q;
  logic [7:0] ui_q;
  logic [7:0] ui_now;
  logic rise_a;
  logic rise_b;

  ////////////////////////////////////////////////////////////////////////////
  // Edge finder; a rise may sit at either half of the bit
  always_comb
  begin
    ui_now = (lanes != prev_lanes_q) ? 8'h00 : ui_q + 8'h01;
    rise_a = rclk[0] & ~prev_half_q;
    rise_b = rclk[1] & ~rclk[0];
  end

  // Capture on each rising clock edge, as a real receiver would
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rise_cnt_q <= 16'h0000;
      last_pos_q <= 8'h00;
      cap_q <= 4'h0;
      prev_lanes_q <= 4'h0;
      prev_half_q <= 1'b0;
      ui_q <= 8'h00;
    end
    else
    begin
      if (rise_a || rise_b)
      begin
        rise_cnt_q <= rise_cnt_q + 16'h0001;
        last_pos_q <= {ui_now[6:0], 1'b0} + {7'h00, rise_b};
        cap_q <= lanes;
      end
      prev_lanes_q <= lanes;
      prev_half_q <= rclk[1];
      ui_q <= ui_now;
    end
  end
endmodule // bcdr_sink

// [bcdr_top_tb.sv]
// Purpose: Self-checking bench for the burst receiver setup and output stage.
// Assumes: Inputs change on the falling clock edge only.
// Notes: Clock shape is judged by rise counts over fixed 32-cycle windows.
`timescale 1ns/1ps
`include "bcdr_defines.svh"
module bcdr_top_tb;
  logic clk;
  logic sys_rst;
  logic rx_bit;
  logic rx_valid;
  logic rx_ready;
  logic reg_wr_en;
  logic reg_rd_en;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_q;
  logic reg_ack_q;
  logic ref_lock_en_q;
  logic [1:0] ref_range_q;
  logic [3:0] ref_div_q;
  logic [8:0] lock_multiple_q;
  logic acq_start_q;
  logic [3:0] par_lanes_q;
  logic data_oe_q;
  logic [1:0] rclk_out_q;
  logic rclk_oe_q;
  logic [15:0] rise_cnt;
  logic [7:0] last_pos;
  logic [7:0] ppos [4] = '{8'h04, 8'h00, 8'h05, 8'h01};
  int num_errors;
  int comparisons;

  bcdr_top #(.FIFO_DEPTH(16)) dut (.clk(clk), .sys_rst(sys_rst), .rx_bit(rx_bit),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q), .ref_lock_en_q(ref_lock_en_q),
    .ref_range_q(ref_range_q), .ref_div_q(ref_div_q), .lock_multiple_q(lock_multiple_q),
    .acq_start_q(acq_start_q), .par_lanes_q(par_lanes_q), .data_oe_q(data_oe_q),
    .rclk_out_q(rclk_out_q), .rclk_oe_q(rclk_oe_q));

  bcdr_sink sink (.clk(clk), .sys_rst(sys_rst), .lanes(par_lanes_q), .rclk(rclk_out_q),
    .rise_cnt_q(rise_cnt), .last_pos_q(last_pos), .cap_q());

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock, 8 ns
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Shared compare, reports at once
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One register access after an idle cycle, so a strobe never drops and
  // rises in the same time step; ack and read data land one cycle later
  task acc(input logic wr, input logic [2:0] a, input logic [7:0] d, input logic ack,
           input logic [7:0] rexp);
    @(negedge clk);
    reg_wr_en = wr;
    reg_rd_en = ~wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    chk(16'(reg_ack_q), 16'(ack), "ack");
    if (!wr)
      chk(16'(reg_rdata_q), 16'(rexp), "read data");
  endtask

  // Earliest bit of a nibble is n[3]; leaves rx_valid high
  task send_nib(input logic [3:0] n);
    for (int i = 3; i >= 0; i--)
    begin
      rx_valid = 1'b1;
      rx_bit = n[i];
      @(negedge clk);
    end
  endtask

  // Alternating nibbles; second half of the stream is the measured window
  task stream(input logic [3:0] a, input logic [3:0] b, input logic [15:0] cnt,
              input logic [7:0] pos);
    logic [15:0] c0;
    c0 = 16'h0000;
    for (int k = 0; k < 16; k++)
    begin
      if (k == 8)
        c0 = rise_cnt;
      send_nib(k[0] ? b : a);
    end
    rx_valid = 1'b0;
    chk(rise_cnt - c0, cnt, "clock rises");
    if (cnt != 16'h0000)
      chk(16'(last_pos), 16'(pos), "rise position");
  endtask

  // Bounded waits; a spent bound ends the run
  task wait_lanes(input logic [3:0] e);
    int n;
    n = 0;
    while (par_lanes_q !== e && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(par_lanes_q), 16'(e), "lanes");
    if (n >= 60)
      close_out();
  endtask

  task wait_ready;
    int n;
    n = 0;
    while (rx_ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(rx_ready), 16'h0001, "ready");
    if (n >= 200)
      close_out();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    num_errors = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    rx_bit = 1'b0;
    rx_valid = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk(16'(ref_div_q), 16'h0001, "reset divider");
    chk(16'(lock_multiple_q), 16'h0001, "reset multiple");
    chk({14'h0, data_oe_q, rclk_oe_q}, 16'h0003, "reset enables");
    for (int a = 0; a < 5; a++)
      acc(1'b0, a[2:0], 8'h00, 1'b1, 8'h00);
    // Every range and ratio codes 0 to 8, with readback
    for (int r = 0; r < 4; r++)
      for (int n = 0; n < 9; n++)
      begin
        acc(1'b1, `BCDR_SUB_LOCKSET, {r[1:0], n[3:0], 2'b01}, 1'b1, 8'h00);
        @(negedge clk);
        chk(16'(ref_div_q), 16'(4'h1 << r), "divider");
        chk(16'(lock_multiple_q), 16'(9'h001 << n), "multiple");
        chk({13'h0, ref_lock_en_q, ref_range_q}, 16'({1'b1, r[1:0]}), "range");
        acc(1'b0, `BCDR_SUB_LOCKSET, 8'h00, 1'b1, {r[1:0], n[3:0], 2'b01});
      end
    // Ratio codes past the top of the table stay at the largest multiple
    acc(1'b1, `BCDR_SUB_LOCKSET, 8'h3d, 1'b1, 8'h00);
    @(negedge clk);
    chk(16'(lock_multiple_q), 16'h0100, "ratio clamp");
    // Acquisition start only on a 0 to 1 write
    acc(1'b1, `BCDR_SUB_ACQ, 8'h20, 1'b1, 8'h00);
    chk(16'(acq_start_q), 16'h0001, "acq pulse");
    @(negedge clk);
    chk(16'(acq_start_q), 16'h0000, "acq pulse width");
    acc(1'b1, `BCDR_SUB_ACQ, 8'h20, 1'b1, 8'h00);
    chk(16'(acq_start_q), 16'h0000, "acq no edge");
    acc(1'b1, `BCDR_SUB_ACQ, 8'h00, 1'b1, 8'h00);
    acc(1'b1, `BCDR_SUB_ACQ, 8'h20, 1'b1, 8'h00);
    chk(16'(acq_start_q), 16'h0001, "acq again");
    acc(1'b1, 3'h5, 8'hff, 1'b0, 8'h00);
    acc(1'b0, 3'h5, 8'h00, 1'b0, 8'h00);
    // Lane order, default then reversed
    send_nib(4'hd);
    rx_valid = 1'b0;
    wait_lanes(4'hd);
    acc(1'b1, `BCDR_SUB_FMT, 8'h20, 1'b1, 8'h00);
    repeat (8) @(negedge clk);
    send_nib(4'hd);
    rx_valid = 1'b0;
    wait_lanes(4'hb);
    // Phase codes in parallel full-rate mode, then parallel DDR rate
    for (int p = 0; p < 4; p++)
    begin
      acc(1'b1, `BCDR_SUB_FMT, {4'h0, p[1:0], 2'b00}, 1'b1, 8'h00);
      stream(4'hd, 4'h2, 16'h0008, ppos[p]);
    end
    acc(1'b1, `BCDR_SUB_FMT, 8'h10, 1'b1, 8'h00);
    stream(4'hd, 4'h2, 16'h0004, 8'h04);
    // Serial half and full rate
    acc(1'b1, `BCDR_SUB_FMT, 8'h00, 1'b1, 8'h00);
    acc(1'b1, `BCDR_SUB_PATH, 8'h80, 1'b1, 8'h00);
    stream(4'ha, 4'ha, 16'h0010, 8'h01);
    chk(16'(par_lanes_q[3:1]), 16'h0000, "serial upper lanes");
    acc(1'b0, `BCDR_SUB_STATUS, 8'h00, 1'b1, 8'h02);
    acc(1'b1, `BCDR_SUB_PATH, 8'h81, 1'b1, 8'h00);
    stream(4'ha, 4'ha, 16'h0020, 8'h01);
    // Clock buffers off
    acc(1'b1, `BCDR_SUB_PATH, 8'h20, 1'b1, 8'h00);
    stream(4'hd, 4'h2, 16'h0000, 8'h00);
    chk({13'h0, rclk_oe_q, rclk_out_q}, 16'h0000, "clock off");
    // Data buffers off: output stalls, buffer fills and refuses
    acc(1'b1, `BCDR_SUB_PATH, 8'h60, 1'b1, 8'h00);
    repeat (16) @(negedge clk);
    chk({11'h0, data_oe_q, par_lanes_q}, 16'h0000, "data off");
    repeat (18) send_nib(4'hd);
    rx_valid = 1'b0;
    @(negedge clk);
    chk(16'(rx_ready), 16'h0000, "buffer full");
    acc(1'b0, `BCDR_SUB_STATUS, 8'h00, 1'b1, 8'h01);
    acc(1'b1, `BCDR_SUB_STATUS, 8'h01, 1'b1, 8'h00);
    acc(1'b0, `BCDR_SUB_STATUS, 8'h00, 1'b1, 8'h00);
    acc(1'b1, `BCDR_SUB_PATH, 8'h00, 1'b1, 8'h00);
    wait_ready();
    wait_lanes(4'hd);
    chk(16'(data_oe_q), 16'h0001, "data on");
    close_out();
  end
endmodule // bcdr_top_tb
